// file: rtl/encoder_command_executor.sv
`timescale 1ns/100ps

// Functional notes
// R01: Event command adds exactly one to counter
// R02: Host sets protection level zero before switch
// R03: Switch loads targets, writes config without offsets
// R04: Switch then restores original mode and protection
// R05: Switch flags checksum error if targets differ
// R06: Targets become active at reset or soft reset
// R07: Host issues switch after all other configuration
// R08: Three-bit target mode encodes eight interface modes
// R09: Two-bit target protection encodes four levels
// R10: Verify checks both checksums, flags mismatch
// R11: Recalculate stores both checksums as references
// R12: Clock pin high and low commands
// R13: Data pin sampled before clock pin changes
// R14: Host uses clock pin commands without multiturn
// R15: Preset pin falling edge runs configured command; code does so only in modes MODE_SERIAL_BIDIR and above
// R16: Pin field 0x00/0xFF idle, 0x01-0x10 commands
// R17: After reset, effective offset adds nonius data
// R18: Each conversion subtracts effective offset
// R19: Stored offset independent of quadrature resolution
// R20: Preset from register command or pin edge
// R21: Preset sequence stops, computes, saves, restarts
// R22: Command codes 0x01-0x10 decoded, others idle
// R23: Triggers ignored while a command executes
module encoder_command_executor #(
  parameter int POS_W = 36
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire enc_cmd_pkg::reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic port_pin_zero_i,
  input wire logic multiturn_data_pin_i,
  output logic multiturn_clock_pin_o,
  input wire logic conv_strobe_i,
  input wire logic [POS_W-1:0] sync_position_i,
  input wire logic [POS_W-1:0] nonius_ext_i,
  output logic [POS_W-1:0] position_o,
  output logic position_valid_o,
  output logic quad_run_o,
  output logic [2:0] interface_mode_sel_o,
  output logic [1:0] register_protect_level_o,
  output logic svc_req_o,
  output logic [7:0] svc_code_o,
  input wire enc_cmd_pkg::svc_rsp_t svc_rsp_i,
  output logic busy_o
);

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_SVC,
    ST_SWITCH,
    ST_PRESET,
    ST_PRE_SAVE
  } exec_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // State
  exec_state_t state_ff;
  logic [POS_W-1:0] stored_offset_ff;
  logic [POS_W-1:0] eff_offset_ff;
  logic [POS_W-1:0] setpoint_ff;
  logic [7:0] pin_cmd_ff;
  logic [7:0] dev_start_ff;
  logic [7:0] ram_end_ff;
  logic [2:0] tgt_mode_ff;
  logic [1:0] tgt_prot_ff;
  logic [2:0] act_mode_ff;
  logic [1:0] act_prot_ff;
  logic pin_sample_ff;
  logic [7:0] event_cnt_ff;
  logic eeprom_fault_ff;
  logic crc_err_ff;
  logic crc_disable_ff;
  logic [1:0] mt_mode_ff;
  logic [15:0] crc16_ref_ff;
  logic [7:0] crc8_ref_ff;
  logic [7:0] cur_cmd_ff;
  logic pin_prev_ff;
  logic mtc_ff;
  logic [7:0] rdata_ff;
  logic [POS_W-1:0] pos_ff;
  logic pos_valid_ff;
  logic quad_run_ff;
  logic [2:0] out_mode_ff;
  logic [1:0] out_prot_ff;
  logic svc_req_ff;
  logic [7:0] svc_code_ff;
  logic busy_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire wr_en = ce_i && reg_req_i.wr;
  wire [7:0] wd = reg_req_i.wdata;
  wire [7:0] wa = reg_req_i.addr;
  wire idle = (state_ff == ST_IDLE);
  wire reg_cmd_wr = wr_en && (wa == enc_cmd_pkg::OFS_COMMAND);
  wire preset_pin_mode = (act_mode_ff >= enc_cmd_pkg::MODE_SERIAL_BIDIR); // R15
  wire pin_fall = pin_prev_ff && !port_pin_zero_i;
  wire pin_cmd_valid = (pin_cmd_ff >= enc_cmd_pkg::CMD_FIRST) &&
    (pin_cmd_ff <= enc_cmd_pkg::CMD_LAST); // R16
  wire pin_trig = ce_i && preset_pin_mode && pin_fall && pin_cmd_valid; // R15
  wire [7:0] trig_code = reg_cmd_wr ? wd : pin_cmd_ff;
  wire trig_any = reg_cmd_wr || pin_trig;
  wire code_ok = (trig_code >= enc_cmd_pkg::CMD_FIRST) &&
    (trig_code <= enc_cmd_pkg::CMD_LAST); // R22
  wire start = idle && trig_any && code_ok; // R23
  wire is_preset = (trig_code == enc_cmd_pkg::CMD_RAM_PRESET) ||
    (trig_code == enc_cmd_pkg::CMD_EEPROM_PRESET); // R20
  wire is_event = (trig_code == enc_cmd_pkg::CMD_EVENT_COUNT);
  wire is_mtc_hi = (trig_code == enc_cmd_pkg::CMD_MTC_HIGH);
  wire is_mtc_lo = (trig_code == enc_cmd_pkg::CMD_MTC_LOW);
  wire is_switch = (trig_code == enc_cmd_pkg::CMD_SWITCH);
  wire svc_done = ce_i && svc_req_ff && svc_rsp_i.done;
  wire crc_mismatch = (svc_rsp_i.crc16 != crc16_ref_ff) ||
    (svc_rsp_i.crc8 != crc8_ref_ff); // R10
  wire tgt_differs = (tgt_mode_ff != act_mode_ff) ||
    (tgt_prot_ff != act_prot_ff);
  wire reset_done = svc_done && ((cur_cmd_ff == enc_cmd_pkg::CMD_SOFT_RESET) ||
    (cur_cmd_ff == enc_cmd_pkg::CMD_ABSOLUTE_REDEFINE_CMD));
  wire [POS_W-1:0] preset_eff = sync_position_i - setpoint_ff; // R21
  wire [POS_W-1:0] preset_stored = preset_eff - nonius_ext_i; // R21
  wire st1_clr_wr = wr_en && (wa == enc_cmd_pkg::OFS_STATUS_ONE);
  wire set_crc_err = (state_ff == ST_SWITCH && svc_done &&
    !crc_disable_ff && tgt_differs) ||
    (svc_done && cur_cmd_ff == enc_cmd_pkg::CMD_CRC_VERIFY && crc_mismatch);
  wire set_eeprom_fault = svc_done && svc_rsp_i.err;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] rd_val;
  always_comb begin
    rd_val = enc_cmd_pkg::BYTE_RST;
    case (reg_req_i.addr)
      enc_cmd_pkg::OFS_OUT_OFF_NIB0: rd_val = {stored_offset_ff[3:0], 4'h0};
      enc_cmd_pkg::OFS_OUT_OFF_B1: rd_val = stored_offset_ff[11:4];
      enc_cmd_pkg::OFS_OUT_OFF_B2: rd_val = stored_offset_ff[19:12];
      enc_cmd_pkg::OFS_OUT_OFF_B3: rd_val = stored_offset_ff[27:20];
      enc_cmd_pkg::OFS_OUT_OFF_B4: rd_val = stored_offset_ff[35:28];
      enc_cmd_pkg::OFS_EFF_OFF_B2: rd_val = eff_offset_ff[19:12];
      enc_cmd_pkg::OFS_EFF_OFF_B3: rd_val = eff_offset_ff[27:20];
      enc_cmd_pkg::OFS_EFF_OFF_B4: rd_val = eff_offset_ff[35:28];
      enc_cmd_pkg::OFS_PRESET_NIB0: rd_val = {setpoint_ff[3:0], 4'h0};
      enc_cmd_pkg::OFS_PRESET_B1: rd_val = setpoint_ff[11:4];
      enc_cmd_pkg::OFS_PRESET_B2: rd_val = setpoint_ff[19:12];
      enc_cmd_pkg::OFS_PRESET_B3: rd_val = setpoint_ff[27:20];
      enc_cmd_pkg::OFS_PRESET_B4: rd_val = setpoint_ff[35:28];
      enc_cmd_pkg::OFS_PIN_CMD: rd_val = pin_cmd_ff;
      enc_cmd_pkg::OFS_BUS_DEV_START: rd_val = dev_start_ff;
      enc_cmd_pkg::OFS_BUS_RAM_END: rd_val = ram_end_ff;
      enc_cmd_pkg::OFS_SWITCH_TARGET:
        rd_val = {tgt_prot_ff, 3'h0, tgt_mode_ff[2:1], pin_sample_ff}; // R13
      enc_cmd_pkg::OFS_COMMAND: rd_val = cur_cmd_ff;
      enc_cmd_pkg::OFS_STATUS_ONE:
        rd_val = {6'h00, crc_err_ff, eeprom_fault_ff};
      enc_cmd_pkg::OFS_EVENT_COUNT: rd_val = event_cnt_ff;
      enc_cmd_pkg::OFS_CONTROL:
        rd_val = {2'h0, mt_mode_ff, 3'h0, crc_disable_ff};
      default: rd_val = enc_cmd_pkg::BYTE_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers written by the host
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      setpoint_ff <= '0;
      pin_cmd_ff <= enc_cmd_pkg::CMD_NONE;
      dev_start_ff <= enc_cmd_pkg::BYTE_RST;
      ram_end_ff <= enc_cmd_pkg::BYTE_RST;
      tgt_mode_ff <= enc_cmd_pkg::MODE_RST;
      tgt_prot_ff <= enc_cmd_pkg::PROT_RST;
      crc_disable_ff <= 1'b0;
      mt_mode_ff <= 2'h0;
    end else if (wr_en) begin
      unique case (wa)
        enc_cmd_pkg::OFS_PRESET_NIB0: setpoint_ff[3:0] <= wd[7:4];
        enc_cmd_pkg::OFS_PRESET_B1: setpoint_ff[11:4] <= wd;
        enc_cmd_pkg::OFS_PRESET_B2: setpoint_ff[19:12] <= wd;
        enc_cmd_pkg::OFS_PRESET_B3: setpoint_ff[27:20] <= wd;
        enc_cmd_pkg::OFS_PRESET_B4: setpoint_ff[35:28] <= wd;
        enc_cmd_pkg::OFS_PIN_CMD: pin_cmd_ff <= wd;
        enc_cmd_pkg::OFS_BUS_DEV_START: dev_start_ff <= wd;
        enc_cmd_pkg::OFS_BUS_RAM_END: ram_end_ff <= wd;
        enc_cmd_pkg::OFS_SWITCH_TARGET: begin
          tgt_mode_ff <= wd[enc_cmd_pkg::TGT_MODE_LSB +: 3]; // R08
          tgt_prot_ff <= wd[enc_cmd_pkg::TGT_PROT_LSB +: 2]; // R09
        end
        enc_cmd_pkg::OFS_CONTROL: begin
          crc_disable_ff <= wd[enc_cmd_pkg::CTL_CRC_DISABLE_BIT];
          mt_mode_ff <= wd[enc_cmd_pkg::CTL_MT_MODE_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored and effective offsets
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      stored_offset_ff <= '0;
      eff_offset_ff <= '0;
    end else if (ce_i) begin
      if (state_ff == ST_BOOT || reset_done) begin
        eff_offset_ff <= stored_offset_ff + nonius_ext_i; // R17
      end else if (state_ff == ST_PRESET) begin
        eff_offset_ff <= preset_eff; // R21
        stored_offset_ff <= preset_stored; // R21 R19
      end else if (wr_en) begin
        unique case (wa)
          enc_cmd_pkg::OFS_OUT_OFF_NIB0: stored_offset_ff[3:0] <= wd[7:4];
          enc_cmd_pkg::OFS_OUT_OFF_B1: stored_offset_ff[11:4] <= wd;
          enc_cmd_pkg::OFS_OUT_OFF_B2: stored_offset_ff[19:12] <= wd;
          enc_cmd_pkg::OFS_OUT_OFF_B3: stored_offset_ff[27:20] <= wd;
          enc_cmd_pkg::OFS_OUT_OFF_B4: stored_offset_ff[35:28] <= wd;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_ff <= ST_BOOT;
      cur_cmd_ff <= enc_cmd_pkg::CMD_NONE;
      svc_req_ff <= 1'b0;
      svc_code_ff <= enc_cmd_pkg::CMD_NONE;
      quad_run_ff <= 1'b1;
      busy_ff <= 1'b1;
    end else if (ce_i) begin
      unique case (state_ff)
        ST_BOOT: begin
          state_ff <= ST_IDLE;
          busy_ff <= 1'b0;
        end
        ST_IDLE: begin
          if (start) begin
            cur_cmd_ff <= trig_code;
            if (is_preset) begin
              quad_run_ff <= 1'b0; // R21
              busy_ff <= 1'b1; // R23
              state_ff <= ST_PRESET;
            end else if (is_switch) begin
              svc_req_ff <= 1'b1; // R03
              busy_ff <= 1'b1; // R23
              svc_code_ff <= trig_code;
              state_ff <= ST_SWITCH;
            end else if (!(is_event || is_mtc_hi || is_mtc_lo)) begin
              busy_ff <= 1'b1; // R23
              svc_req_ff <= 1'b1;
              svc_code_ff <= trig_code;
              state_ff <= ST_SVC;
            end
          end
        end
        ST_PRESET: begin
          if (cur_cmd_ff == enc_cmd_pkg::CMD_EEPROM_PRESET) begin
            svc_req_ff <= 1'b1; // R21
            svc_code_ff <= cur_cmd_ff;
            state_ff <= ST_PRE_SAVE;
          end else begin
            busy_ff <= 1'b0;
            quad_run_ff <= 1'b1; // R21
            state_ff <= ST_IDLE;
          end
        end
        ST_PRE_SAVE: begin
          if (svc_done) begin
            svc_req_ff <= 1'b0;
            busy_ff <= 1'b0;
            quad_run_ff <= 1'b1; // R21
            state_ff <= ST_IDLE;
          end
        end
        ST_SWITCH, ST_SVC: begin
          if (svc_done) begin
            svc_req_ff <= 1'b0;
            busy_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode, protection, checksums and status
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      act_mode_ff <= enc_cmd_pkg::MODE_RST;
      act_prot_ff <= enc_cmd_pkg::PROT_RST;
      out_mode_ff <= enc_cmd_pkg::MODE_RST;
      out_prot_ff <= enc_cmd_pkg::PROT_RST;
      crc16_ref_ff <= 16'h0000;
      crc8_ref_ff <= 8'h00;
      eeprom_fault_ff <= 1'b0;
      crc_err_ff <= 1'b0;
    end else if (ce_i) begin
      if (start && is_switch) begin
        out_mode_ff <= tgt_mode_ff; // R03
        out_prot_ff <= tgt_prot_ff; // R03
      end else if (state_ff == ST_SWITCH && svc_done) begin
        out_mode_ff <= act_mode_ff; // R04
        out_prot_ff <= act_prot_ff; // R04
      end else if (reset_done &&
                   cur_cmd_ff == enc_cmd_pkg::CMD_SOFT_RESET) begin
        act_mode_ff <= tgt_mode_ff; // R06
        act_prot_ff <= tgt_prot_ff; // R06
        out_mode_ff <= tgt_mode_ff; // R06
        out_prot_ff <= tgt_prot_ff; // R06
      end
      if (svc_done && cur_cmd_ff == enc_cmd_pkg::CMD_CRC_RECALC) begin
        crc16_ref_ff <= svc_rsp_i.crc16; // R11
        crc8_ref_ff <= svc_rsp_i.crc8; // R11
      end
      if (set_eeprom_fault) begin
        eeprom_fault_ff <= 1'b1;
      end else if (st1_clr_wr && wd[enc_cmd_pkg::ST1_EEPROM_FAULT_BIT]) begin
        eeprom_fault_ff <= 1'b0;
      end
      if (set_crc_err) begin
        crc_err_ff <= 1'b1; // R05 R10
      end else if (st1_clr_wr && wd[enc_cmd_pkg::ST1_CRC_ERR_BIT]) begin
        crc_err_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event counter and multiturn clock pin
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      event_cnt_ff <= 8'h00;
      mtc_ff <= 1'b0;
      pin_sample_ff <= 1'b0;
    end else if (ce_i && start) begin
      if (is_event) begin
        event_cnt_ff <= event_cnt_ff + 8'h01; // R01
      end
      if (is_mtc_hi || is_mtc_lo) begin
        pin_sample_ff <= multiturn_data_pin_i; // R13
        mtc_ff <= is_mtc_hi; // R12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin edge, position output, register read
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pin_prev_ff <= 1'b1;
      pos_ff <= '0;
      pos_valid_ff <= 1'b0;
      rdata_ff <= enc_cmd_pkg::BYTE_RST;
    end else if (ce_i) begin
      pin_prev_ff <= port_pin_zero_i;
      pos_valid_ff <= conv_strobe_i;
      if (conv_strobe_i) begin
        pos_ff <= sync_position_i - eff_offset_ff; // R18
      end
      if (reg_req_i.rd) begin
        rdata_ff <= rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_o = rdata_ff;
  assign multiturn_clock_pin_o = mtc_ff;
  assign position_o = pos_ff;
  assign position_valid_o = pos_valid_ff;
  assign quad_run_o = quad_run_ff;
  assign interface_mode_sel_o = out_mode_ff;
  assign register_protect_level_o = out_prot_ff;
  assign svc_req_o = svc_req_ff;
  assign svc_code_o = svc_code_ff;
  assign busy_o = busy_ff;

endmodule : encoder_command_executor

// file: rtl/enc_cmd_pkg.sv
package enc_cmd_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] OFS_OUT_OFF_NIB0 = 8'h1e;
  localparam logic [7:0] OFS_OUT_OFF_B1 = 8'h1f;
  localparam logic [7:0] OFS_EFF_OFF_B2 = 8'h20;
  localparam logic [7:0] OFS_EFF_OFF_B3 = 8'h21;
  localparam logic [7:0] OFS_EFF_OFF_B4 = 8'h22;
  localparam logic [7:0] OFS_PIN_CMD = 8'h25;
  localparam logic [7:0] OFS_OUT_OFF_B2 = 8'h48;
  localparam logic [7:0] OFS_OUT_OFF_B3 = 8'h49;
  localparam logic [7:0] OFS_OUT_OFF_B4 = 8'h4a;
  localparam logic [7:0] OFS_PRESET_NIB0 = 8'h4d;
  localparam logic [7:0] OFS_PRESET_B1 = 8'h4e;
  localparam logic [7:0] OFS_PRESET_B2 = 8'h4f;
  localparam logic [7:0] OFS_PRESET_B3 = 8'h50;
  localparam logic [7:0] OFS_PRESET_B4 = 8'h51;
  localparam logic [7:0] OFS_BUS_DEV_START = 8'h5b;
  localparam logic [7:0] OFS_BUS_RAM_END = 8'h5d;
  localparam logic [7:0] OFS_SWITCH_TARGET = 8'h60;
  localparam logic [7:0] OFS_COMMAND = 8'h75;
  localparam logic [7:0] OFS_STATUS_ONE = 8'h76;
  localparam logic [7:0] OFS_EVENT_COUNT = 8'h77;
  localparam logic [7:0] OFS_CONTROL = 8'h78;

  // Field positions
  localparam int TGT_MODE_LSB = 0;
  localparam int TGT_PROT_LSB = 6;
  localparam int PIN_SAMPLE_BIT = 0;
  localparam int ST1_EEPROM_FAULT_BIT = 0;
  localparam int ST1_CRC_ERR_BIT = 1;
  localparam int CTL_CRC_DISABLE_BIT = 0;
  localparam int CTL_MT_MODE_LSB = 4;

  // Reset values
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] PROT_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Command codes
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_FIRST = 8'h01;
  localparam logic [7:0] CMD_ABSOLUTE_REDEFINE_CMD = 8'h03;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h07;
  localparam logic [7:0] CMD_RAM_PRESET = 8'h08;
  localparam logic [7:0] CMD_EEPROM_PRESET = 8'h09;
  localparam logic [7:0] CMD_EVENT_COUNT = 8'h0b;
  localparam logic [7:0] CMD_SWITCH = 8'h0c;
  localparam logic [7:0] CMD_CRC_VERIFY = 8'h0d;
  localparam logic [7:0] CMD_CRC_RECALC = 8'h0e;
  localparam logic [7:0] CMD_MTC_HIGH = 8'h0f;
  localparam logic [7:0] CMD_MTC_LOW = 8'h10;
  localparam logic [7:0] CMD_LAST = 8'h10;

  // Interface modes
  localparam logic [2:0] MODE_SPI_TRI = 3'h0;
  localparam logic [2:0] MODE_SPI = 3'h1;
  localparam logic [2:0] MODE_SERIAL_BIDIR = 3'h2;
  localparam logic [2:0] MODE_QUAD_ABZ = 3'h3;
  localparam logic [2:0] MODE_SSI = 3'h4;
  localparam logic [2:0] MODE_SSI_ERR_LOW = 3'h5;
  localparam logic [2:0] MODE_SSI_ERR_HIGH = 3'h6;
  localparam logic [2:0] MODE_EXT_SSI = 3'h7;

  // Protection levels
  localparam logic [1:0] PROT_ZERO = 2'h0;
  localparam logic [1:0] PROT_ONE_LOCKED = 2'h1;
  localparam logic [1:0] PROT_ONE_OPEN = 2'h2;
  localparam logic [1:0] PROT_ONE_RESET_ONLY = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [15:0] crc16;
    logic [7:0] crc8;
  } svc_rsp_t;

endpackage : enc_cmd_pkg

// file: bench/svc_responder.sv
`timescale 1ns/100ps
module svc_responder (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic req_i,
  input wire logic [3:0] lat_i,
  input wire logic err_i,
  input wire logic [15:0] crc16_i,
  input wire logic [7:0] crc8_i,
  output enc_cmd_pkg::svc_rsp_t rsp_o
);
  logic [3:0] cnt_ff;
  logic done_ff;
  logic fire;
  assign fire = req_i && !done_ff && cnt_ff == lat_i;
  // Latency counter, one done pulse per request
  always_ff @(posedge clk_i) begin
    if (srst_i || !req_i || done_ff) begin
      cnt_ff <= 4'h0;
    end else if (!fire) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
    done_ff <= !srst_i && fire;
  end
  // Idle lines carry inverted data
  assign rsp_o = done_ff ? {1'b1, err_i, crc16_i, crc8_i}
                         : {1'b0, ~err_i, ~crc16_i, ~crc8_i};
endmodule : svc_responder

// file: bench/encoder_command_executor_chk.sv
`timescale 1ns/100ps
module encoder_command_executor_chk #(
  parameter int POS_W = 36
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire enc_cmd_pkg::reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic port_pin_zero_i,
  input wire logic multiturn_data_pin_i,
  input wire logic multiturn_clock_pin_o,
  input wire logic conv_strobe_i,
  input wire logic [POS_W-1:0] sync_position_i,
  input wire logic [POS_W-1:0] nonius_ext_i,
  input wire logic [POS_W-1:0] position_o,
  input wire logic position_valid_o,
  input wire logic quad_run_o,
  input wire logic [2:0] interface_mode_sel_o,
  input wire logic [1:0] register_protect_level_o,
  input wire logic svc_req_o,
  input wire logic [7:0] svc_code_o,
  input wire enc_cmd_pkg::svc_rsp_t svc_rsp_i,
  input wire logic busy_o
);
  logic cmd_wr;
  logic cmd_go;
  logic [4:0] orig_ff;
  assign cmd_wr = ce_i && reg_req_i.wr &&
    reg_req_i.addr == enc_cmd_pkg::OFS_COMMAND;
  assign cmd_go = cmd_wr && !busy_o;
  always_ff @(posedge sys_clk_i) begin
    if (cmd_go && reg_req_i.wdata == enc_cmd_pkg::CMD_SWITCH) begin
      orig_ff <= {register_protect_level_o, interface_mode_sel_o};
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_cmd(logic [7:0] code);
    cmd_go && reg_req_i.wdata == code;
  endsequence
  sequence s_quad_blip;
    !quad_run_o ##1 quad_run_o;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  chk_mtc_set_high: assert property (s_cmd(8'h0f) |=> multiturn_clock_pin_o)
    else $error("clock pin not set");
  chk_mtc_set_low: assert property (s_cmd(8'h10) |=> !multiturn_clock_pin_o)
    else $error("clock pin not cleared");
  chk_busy_ignore: assert property (busy_o && cmd_wr && !multiturn_clock_pin_o
    |=> !multiturn_clock_pin_o) else $error("command taken while busy");
  chk_ram_preset_blip: assert property (s_cmd(8'h08) |=> s_quad_blip)
    else $error("ram preset converter stop wrong");
  chk_eeprom_preset_stop: assert property (s_cmd(8'h09)
    |=> !quad_run_o ##1 (svc_req_o && !quad_run_o))
    else $error("eeprom preset sequence wrong");
  chk_switch_request: assert property (s_cmd(8'h0c)
    |=> svc_req_o && svc_code_o == 8'h0c) else $error("switch not started");
  chk_switch_restore: assert property (svc_req_o && svc_rsp_i.done &&
    svc_code_o == 8'h0c |=> orig_ff ==
    {register_protect_level_o, interface_mode_sel_o})
    else $error("mode not restored");
  chk_svc_hold: assert property (svc_req_o && !svc_rsp_i.done
    |=> svc_req_o && $stable(svc_code_o)) else $error("service dropped");
  chk_valid_follow: assert property (conv_strobe_i && ce_i
    |=> position_valid_o) else $error("no valid after conversion");
endmodule : encoder_command_executor_chk

bind encoder_command_executor encoder_command_executor_chk #(
  .POS_W(POS_W)) u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .ce_i(ce_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .port_pin_zero_i(port_pin_zero_i),
  .multiturn_data_pin_i(multiturn_data_pin_i),
  .multiturn_clock_pin_o(multiturn_clock_pin_o),
  .conv_strobe_i(conv_strobe_i), .sync_position_i(sync_position_i),
  .nonius_ext_i(nonius_ext_i), .position_o(position_o),
  .position_valid_o(position_valid_o), .quad_run_o(quad_run_o),
  .interface_mode_sel_o(interface_mode_sel_o),
  .register_protect_level_o(register_protect_level_o),
  .svc_req_o(svc_req_o), .svc_code_o(svc_code_o),
  .svc_rsp_i(svc_rsp_i), .busy_o(busy_o));

// file: bench/encoder_command_executor_tb_top.sv
`timescale 1ns/100ps
module encoder_command_executor_tb_top;
  localparam logic [35:0] P = 36'h8_7654_3210;
  localparam logic [35:0] N = 36'h0_0000_1000;
  localparam logic [35:0] S = 36'h1_2345_6789;
  localparam logic [35:0] EFF = P - S;
  localparam logic [35:0] ST = EFF - N;
  logic clk = 1'b0;
  logic srst = 1'b1;
  enc_cmd_pkg::reg_req_t req = '0;
  logic pin0 = 1'b1;
  logic multiturn_data_pin = 1'b0;
  logic strobe = 1'b0;
  logic [35:0] spos = P;
  logic [35:0] nonius = N;
  logic [3:0] lat = 4'h0;
  logic err = 1'b0;
  logic [15:0] c16 = 16'h1234;
  logic [7:0] c8 = 8'h5a;
  logic [7:0] rdata, scode, rv;
  logic multiturn_clock_pin, valid, qrun, sreq, busy;
  logic [35:0] pos;
  logic [2:0] mode;
  logic [1:0] prot;
  enc_cmd_pkg::svc_rsp_t srsp;
  logic [7:0] oa [4] = '{8'h1f, 8'h48, 8'h49, 8'h4a};
  logic [7:0] bad [3] = '{8'h00, 8'h11, 8'hff};
  int mismatches = 0;
  int checks_done = 0;
  int n;
  always #10 clk = ~clk;
  encoder_command_executor #(.POS_W(36)) u_dut (
    .sys_clk_i(clk), .srst_i(srst), .ce_i(1'b1), .reg_req_i(req),
    .reg_rdata_o(rdata), .port_pin_zero_i(pin0),
    .multiturn_data_pin_i(multiturn_data_pin), .multiturn_clock_pin_o(multiturn_clock_pin),
    .conv_strobe_i(strobe), .sync_position_i(spos),
    .nonius_ext_i(nonius), .position_o(pos), .position_valid_o(valid),
    .quad_run_o(qrun), .interface_mode_sel_o(mode),
    .register_protect_level_o(prot), .svc_req_o(sreq),
    .svc_code_o(scode), .svc_rsp_i(srsp), .busy_o(busy));
  svc_responder u_svc (.clk_i(clk), .srst_i(srst), .req_i(sreq),
    .lat_i(lat), .err_i(err), .crc16_i(c16), .crc8_i(c8), .rsp_o(srsp));
  //////////////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step();
    req = '0;
    step();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step();
    req = '0;
    rv = rdata;
    step();
  endtask : rd
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic wait_idle();
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      step();
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      give_verdict();
    end
  endtask : wait_idle
  task automatic pin_fall(input logic [7:0] code);
    wr(8'h25, code);
    pin0 = 1'b0;
    repeat (4) step();
    pin0 = 1'b1;
    step();
    wait_idle();
  endtask : pin_fall
  task automatic conv();
    strobe = 1'b1;
    step();
    chk(valid, 1'b1);
    strobe = 1'b0;
    step();
  endtask : conv
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) step();
    srst = 1'b0;
    step();
    step();
    wr(8'h78, 8'h00);
    rd(8'h77);
    chk(rv, 8'h00);
    repeat (2) wr(8'h75, 8'h0b);
    rd(8'h77);
    chk(rv, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr(8'h75, bad[i]);
      chk({busy, sreq}, 2'b00);
    end
    rd(8'h77);
    chk(rv, 8'h02);
    pin_fall(8'h0f);
    chk(multiturn_clock_pin, 1'b0);
    for (int i = 0; i < 2; i++) begin
      multiturn_data_pin = (i == 0);
      wr(8'h75, (i == 0) ? 8'h0f : 8'h10);
      chk(multiturn_clock_pin, i == 0);
      rd(8'h60);
      chk(rv[0], i == 0);
    end
    for (int m = 0; m < 8; m++) begin
      for (int p = 0; p < 4; p++) begin
        wr(8'h60, {p[1:0], 3'h0, m[2:0]});
        rd(8'h60);
        chk(rv[7:1], {p[1:0], 3'h0, m[2:1]});
      end
    end
    wr(8'h75, 8'h0e);
    wait_idle();
    for (int i = 0; i < 3; i++) begin
      c16 = (i == 1) ? 16'h1235 : 16'h1234;
      c8 = (i == 2) ? 8'h5b : 8'h5a;
      wr(8'h75, 8'h0d);
      wait_idle();
      rd(8'h76);
      chk(rv[1], i != 0);
      wr(8'h76, 8'h03);
    end
    wr(8'h4d, {S[3:0], 4'h0});
    for (int i = 0; i < 4; i++) wr(8'h4e + 8'(i), S[4+8*i +: 8]);
    conv();
    wr(8'h75, 8'h08);
    wait_idle();
    conv();
    chk({qrun, pos}, {1'b1, S});
    rd(8'h1e);
    chk(rv[7:4], ST[3:0]);
    for (int i = 0; i < 4; i++) begin
      rd(oa[i]);
      chk(rv, ST[4+8*i +: 8]);
    end
    for (int i = 0; i < 3; i++) begin
      rd(8'h20 + 8'(i));
      chk(rv, EFF[12+8*i +: 8]);
    end
    wr(8'h60, 8'h83);
    chk(prot, 2'h0);
    lat = 4'h9;
    err = 1'b1;
    wr(8'h75, 8'h0c);
    chk({sreq, scode, prot, mode}, {1'b1, 8'h0c, 2'h2, 3'h3});
    wr(8'h75, 8'h0f);
    chk(multiturn_clock_pin, 1'b0);
    wait_idle();
    chk({prot, mode}, 5'h00);
    rd(8'h76);
    chk(rv[1:0], 2'h3);
    wr(8'h76, 8'h03);
    rd(8'h76);
    chk(rv[1:0], 2'h0);
    err = 1'b0;
    lat = 4'h2;
    nonius = N + 36'h0_0000_0001;
    wr(8'h75, 8'h07);
    chk(mode, 3'h0);
    wait_idle();
    chk({prot, mode}, {2'h2, 3'h3});
    conv();
    chk(pos, S - 36'h0_0000_0001);
    multiturn_data_pin = 1'b1;
    pin_fall(8'h0f);
    chk(multiturn_clock_pin, 1'b1);
    rd(8'h60);
    chk(rv[0], 1'b1);
    pin_fall(8'h00);
    chk(multiturn_clock_pin, 1'b1);
    pin_fall(8'hff);
    chk(multiturn_clock_pin, 1'b1);
    pin_fall(8'h10);
    chk(multiturn_clock_pin, 1'b0);
    wr(8'h25, 8'h09);
    pin0 = 1'b0;
    n = 0;
    while (sreq !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    if (n >= 20) begin
      mismatches++;
      give_verdict();
    end
    chk({scode, qrun}, {8'h09, 1'b0});
    pin0 = 1'b1;
    wait_idle();
    conv();
    chk({qrun, pos}, {1'b1, S});
    wr(8'h75, 8'h09);
    chk({sreq, qrun}, 2'b10);
    wait_idle();
    conv();
    chk({qrun, pos}, {1'b1, S});
    give_verdict();
  end
endmodule : encoder_command_executor_tb_top
